// ### rtl/dsoc_ctrl.sv
// Control logic of the dual simultaneous-sampling converter
`timescale 1ns/1ps
`default_nettype none
module dsoc_ctrl (
    input  wire logic               sys_clk,
    input  wire logic               rst_b,
    input  wire logic [7:0]         paddr,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic [1:0]         range_select_pins,
    input  wire logic [2:0]         channel_pair_select_pins,
    input  wire logic               reference_source_select,
    input  wire logic               conversion_start,
    input  wire logic [15:0]        sample_a,
    input  wire logic [15:0]        sample_b,
    output logic                    busy,
    output logic [3:0]              conv_chan_a,
    output logic [3:0]              conv_chan_b,
    output logic [1:0]              conv_range_a,
    output logic [1:0]              conv_range_b,
    output logic                    sample_strobe,
    output logic [15:0]             result_a,
    output logic [15:0]             result_b,
    output logic                    result_valid,
    output logic                    int_ref_enable,
    output logic                    shutdown,
    output logic                    software_mode
);
    import dsoc_pkg::*;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Range of one channel out of a packed two-bit-per-channel register
    function automatic logic [1:0] chan_range(input logic [15:0] regv, input logic [2:0] ch);
        chan_range = regv[{ch, 1'b0} +: 2];
    endfunction

    // Average of the accumulated samples, back to a 16-bit code
    function automatic logic [15:0] average(input logic [22:0] sum, input logic [2:0] os);
        logic [22:0] shifted;
        shifted = $signed(sum) >>> os;
        average = shifted[15:0];
    endfunction

    // Span in microvolts per range code; step is span over the code count
    function automatic int span_uv(input logic [1:0] r);
        case (r)
            RANGE_2V5: span_uv = SPAN_2V5_UV;
            RANGE_5V:  span_uv = SPAN_5V_UV;
            default:   span_uv = SPAN_10V_UV;
        endcase
    endfunction

    // Signed sum of one more sample; 23 bits hold 128 full-scale samples
    function automatic logic [22:0] accumulate(input logic [22:0] acc, input logic [15:0] smp);
        accumulate = 23'($signed(acc) + $signed(smp));
    endfunction

    // Index of the last sample in a group of two to the code
    function automatic logic [7:0] last_sample(input logic [2:0] os);
        last_sample = 8'((1 << os) - 1);
    endfunction

    // ----------------------------------------
    // Reset, shutdown and strap latching
    // ----------------------------------------
    logic [7:0]  low_cnt_reg;
    logic        sd_reg;
    logic        rst_seen_reg;
    logic        sw_mode_reg;
    logic        ref_int_reg;
    logic        start_d_reg;
    logic        start_edge;
    logic        regs_clear;

    assign start_edge = conversion_start && !start_d_reg;
    assign regs_clear = !rst_b;

    // Reset held past the shutdown time powers everything down; the count
    // saturates so an arbitrarily long hold cannot wrap back below the limit
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            if (low_cnt_reg < 8'(SHUTDOWN_CYC)) begin
                low_cnt_reg <= low_cnt_reg + 8'h01;
            end
            if (low_cnt_reg >= 8'(SHUTDOWN_CYC - 1)) begin
                sd_reg <= 1'b1;
            end
        end else begin
            low_cnt_reg <= 8'h00;
            sd_reg      <= 1'b0;
        end
    end

    // Straps are caught by the first clock after the release
    // Later changes of the mode and reference straps are ignored until the next reset; range pins stay live in hardware mode
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rst_seen_reg <= 1'b0;
        end else if (!rst_seen_reg) begin
            rst_seen_reg   <= 1'b1;
            sw_mode_reg    <= (range_select_pins == RANGE_REGS);
            ref_int_reg    <= reference_source_select;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            shutdown       <= 1'b1;
            software_mode  <= 1'b0;
            int_ref_enable <= 1'b0;
            start_d_reg    <= 1'b0;
        end else begin
            shutdown       <= sd_reg;
            software_mode  <= sw_mode_reg;
            int_ref_enable <= ref_int_reg && rst_seen_reg;
            start_d_reg    <= conversion_start;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [15:0] cfg_reg;
    logic [8:0]  chan_reg;
    logic [15:0] range_a_reg;
    logic [15:0] range_b_reg;
    logic [2:0]  seq_pos_reg;
    logic        bus_access;
    logic        bus_write;
    logic        sw_active;

    assign bus_access = psel && penable && pready;
    assign bus_write  = bus_access && pwrite && sw_active;
    assign sw_active  = rst_seen_reg && sw_mode_reg;

    // Shutdown and any reset return every register to default
    always_ff @(posedge sys_clk) begin
        if (regs_clear || sd_reg) begin
            cfg_reg     <= 16'h0000;
            chan_reg    <= 9'h000;
        end else if (bus_write) begin
            case (paddr)
                CFG_OFFSET:     cfg_reg     <= pwdata[15:0];
                CHAN_OFFSET:    chan_reg    <= pwdata[8:0];
                default: ;
            endcase
        end
    end

    // Range registers come back to the widest range, the safe default
    always_ff @(posedge sys_clk) begin
        if (regs_clear || sd_reg) begin
            range_a_reg <= RANGE_RESET;
            range_b_reg <= RANGE_RESET;
        end else if (bus_write) begin
            case (paddr)
                RANGE_A_OFFSET: range_a_reg <= pwdata[15:0];
                RANGE_B_OFFSET: range_b_reg <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Register read and error decode
    // ----------------------------------------
    logic [31:0] read_word;
    logic        addr_bad;

    // Holes and unaligned offsets answer with an error, not silence
    assign addr_bad = (paddr[1:0] != 2'h0) || (paddr > CONVERT_OFFSET);

    always_comb begin
        read_word = 32'h00000000;
        case (paddr)
            CFG_OFFSET:     read_word = {16'h0000, cfg_reg};
            CHAN_OFFSET:    read_word = {23'h000000, chan_reg};
            RANGE_A_OFFSET: read_word = {16'h0000, range_a_reg};
            RANGE_B_OFFSET: read_word = {16'h0000, range_b_reg};
            SEQ_OFFSET:     read_word = {29'h00000000, seq_pos_reg};
            STATUS_OFFSET:  read_word = {27'h0000000, shutdown, int_ref_enable,
                                         software_mode, result_valid, busy};
            RESULT_OFFSET:  read_word = {result_b, result_a};
            default:        read_word = 32'h00000000;
        endcase
    end

    // Zero-wait-state slave: ready in the first access cycle only
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && addr_bad;
            prdata  <= 32'h00000000;
            if (psel && !penable && !pwrite) begin
                prdata <= read_word;
            end
        end
    end

    // ----------------------------------------
    // Channel and range selection
    // ----------------------------------------
    logic [2:0] os_code;
    logic [2:0] base_a;
    logic [2:0] base_b;
    logic [2:0] cur_a;
    logic [2:0] cur_b;
    logic [1:0] rng_a;
    logic [1:0] rng_b;

    always_comb begin
        os_code = 3'h0;
        base_a  = channel_pair_select_pins;
        base_b  = channel_pair_select_pins;
        if (sw_active) begin
            os_code = cfg_reg[OS_LSB +: OS_W];
            base_a  = chan_reg[CHA_LSB +: CH_W];
            base_b  = chan_reg[CHB_LSB +: CH_W];
        end
    end

    assign cur_a   = 3'(base_a + seq_pos_reg);
    assign cur_b   = 3'(base_b + seq_pos_reg);

    // Pins apply live in hardware mode; code 00 defers to registers
    always_comb begin
        if (range_select_pins != RANGE_REGS && !sw_active) begin
            rng_a = range_select_pins;
            rng_b = range_select_pins;
        end else begin
            rng_a = chan_range(range_a_reg, cur_a);
            rng_b = chan_range(range_b_reg, cur_b);
        end
    end

    // ----------------------------------------
    // Conversion sequencer with oversampling
    // ----------------------------------------
    dsoc_state_type state_reg;
    logic [7:0]     os_cnt_reg;
    logic [CNT_W-1:0] tick_reg;
    logic [22:0]    acc_a_reg;
    logic [22:0]    acc_b_reg;
    logic [2:0]     seq_len;
    logic           multi;

    // Sequence length only counts while the sequencer or burst is on
    always_comb begin
        multi   = 1'b0;
        seq_len = 3'h0;
        if (sw_active && (cfg_reg[SEQEN_BIT] || cfg_reg[BURST_BIT])) begin
            multi   = 1'b1;
            seq_len = cfg_reg[SEQLEN_LSB +: SEQLEN_W];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b || sd_reg) begin
            state_reg     <= DSOC_IDLE;
            busy          <= 1'b0;
            sample_strobe <= 1'b0;
            result_valid  <= 1'b0;
            os_cnt_reg    <= 8'h00;
            tick_reg      <= '0;
            seq_pos_reg   <= 3'h0;
            acc_a_reg     <= 23'h000000;
            acc_b_reg     <= 23'h000000;
            result_a      <= 16'h0000;
            result_b      <= 16'h0000;
        end else begin
            sample_strobe <= 1'b0;
            result_valid  <= 1'b0;
            case (state_reg)
                DSOC_IDLE: begin
                    if (start_edge && rst_seen_reg) begin
                        sample_strobe <= 1'b1;
                        busy          <= 1'b1;
                        os_cnt_reg    <= 8'h00;
                        tick_reg      <= '0;
                        acc_a_reg     <= 23'h000000;
                        acc_b_reg     <= 23'h000000;
                        state_reg     <= DSOC_SAMPLE;
                    end
                end
                DSOC_SAMPLE: begin
                    // Each sample costs the same time, so busy scales with ratio
                    if (tick_reg == CNT_W'(SAMPLE_CYC - 1)) begin
                        tick_reg  <= '0;
                        acc_a_reg <= accumulate(acc_a_reg, sample_a);
                        acc_b_reg <= accumulate(acc_b_reg, sample_b);
                        if (os_cnt_reg == last_sample(os_code)) begin
                            state_reg <= DSOC_NEXT;
                        end else begin
                            os_cnt_reg    <= os_cnt_reg + 8'h01;
                            sample_strobe <= 1'b1;
                        end
                    end else begin
                        tick_reg <= tick_reg + CNT_W'(1);
                    end
                end
                DSOC_NEXT: begin
                    result_a     <= average(acc_a_reg, os_code);
                    result_b     <= average(acc_b_reg, os_code);
                    result_valid <= 1'b1;
                    acc_a_reg    <= 23'h000000;
                    acc_b_reg    <= 23'h000000;
                    os_cnt_reg   <= 8'h00;
                    if (seq_pos_reg < seq_len) begin
                        seq_pos_reg   <= seq_pos_reg + 3'h1;
                        sample_strobe <= 1'b1;
                        state_reg     <= DSOC_SAMPLE;
                    end else begin
                        seq_pos_reg <= 3'h0;
                        busy        <= 1'b0;
                        state_reg   <= DSOC_IDLE;
                    end
                end
                default: state_reg <= DSOC_IDLE;
            endcase
        end
    end

    // Channel and range in effect, refreshed every clock
    always_ff @(posedge sys_clk) begin
        if (!rst_b || sd_reg) begin
            conv_chan_a  <= 4'h0;
            conv_chan_b  <= 4'h8;
            conv_range_a <= RANGE_10V;
            conv_range_b <= RANGE_10V;
        end else begin
            // Bit 3 selects converter B; diagnostic slot only in software mode
            conv_chan_a  <= {sw_active && chan_reg[DIAG_BIT], cur_a};
            conv_chan_b  <= {1'b1, cur_b};
            conv_range_a <= rng_a;
            conv_range_b <= rng_b;
        end
    end
endmodule
`default_nettype wire

// ### rtl/dsoc_pkg.sv
// Package: register map, field layout, timing and state types of the converter control block
package dsoc_pkg;
    // Register byte offsets
    localparam logic [7:0] CFG_OFFSET      = 8'h00;
    localparam logic [7:0] CHAN_OFFSET     = 8'h04;
    localparam logic [7:0] RANGE_A_OFFSET  = 8'h08;
    localparam logic [7:0] RANGE_B_OFFSET  = 8'h0c;
    localparam logic [7:0] SEQ_OFFSET      = 8'h10;
    localparam logic [7:0] STATUS_OFFSET   = 8'h14;
    localparam logic [7:0] RESULT_OFFSET   = 8'h18;
    localparam logic [7:0] CONVERT_OFFSET  = 8'h1c;

    // Configuration register fields
    localparam int OS_LSB     = 0;
    localparam int OS_W       = 3;
    localparam int BURST_BIT  = 3;
    localparam int SEQEN_BIT  = 4;
    localparam int SEQLEN_LSB = 8;
    localparam int SEQLEN_W   = 3;

    // Channel register fields: A index, B index, diagnostic enable
    localparam int CHA_LSB  = 0;
    localparam int CHB_LSB  = 4;
    localparam int CH_W     = 3;
    localparam int DIAG_BIT = 8;

    // Range codes, two bits per channel
    localparam logic [1:0] RANGE_REGS  = 2'h0;
    localparam logic [1:0] RANGE_2V5   = 2'h1;
    localparam logic [1:0] RANGE_5V    = 2'h2;
    localparam logic [1:0] RANGE_10V   = 2'h3;
    localparam logic [15:0] RANGE_RESET = 16'hffff;

    // Full-scale span in microvolts and code count
    localparam int SPAN_2V5_UV = 5000000;
    localparam int SPAN_5V_UV  = 10000000;
    localparam int SPAN_10V_UV = 20000000;
    localparam int CODE_COUNT  = 65536;

    // Timing
    localparam int CLK_HZ             = 25000000;
    localparam int SHUTDOWN_NS        = 1200;
    localparam int SHUTDOWN_CYC       = (SHUTDOWN_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int SAMPLE_CYC         = 25;
    localparam int CNT_W              = 12;

    typedef enum logic [1:0] {
        DSOC_IDLE,
        DSOC_SAMPLE,
        DSOC_NEXT
    } dsoc_state_type;
endpackage

// ### testbench/dsoc_checker.sv
// Checker: port assertions of the converter control block
`timescale 1ns/1ps
`default_nettype none
module dsoc_checker (
    input wire logic       sys_clk,
    input wire logic       rst_b,
    input wire logic [1:0] range_select_pins,
    input wire logic [2:0] channel_pair_select_pins,
    input wire logic       reference_source_select,
    input wire logic       conversion_start,
    input wire logic       busy,
    input wire logic [3:0] conv_chan_a,
    input wire logic [3:0] conv_chan_b,
    input wire logic [1:0] conv_range_a,
    input wire logic       sample_strobe,
    input wire logic       int_ref_enable,
    input wire logic       shutdown,
    input wire logic       software_mode
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // Saturates so a long hold cannot wrap
    logic [5:0] low_cnt;
    always_ff @(posedge sys_clk) begin
        if (rst_b) begin
            low_cnt <= 6'h00;
        end else if (low_cnt != 6'h3f) begin
            low_cnt <= low_cnt + 6'h01;
        end
    end
    property p_start;
        $rose(conversion_start) && !busy |=> busy && sample_strobe;
    endproperty
    a_start: assert property (p_start) else $error("start not answered");
    property p_pair;
        !software_mode && sample_strobe |-> conv_chan_b == {1'b1, conv_chan_a[2:0]}
            && conv_chan_a == {1'b0, $past(channel_pair_select_pins)};
    endproperty
    a_pair: assert property (p_pair) else $error("pair wrong");
    property p_diag;
        !software_mode && busy |-> !conv_chan_a[3];
    endproperty
    a_diag: assert property (p_diag) else $error("diagnostic in hardware mode");
    property p_range;
        !software_mode && range_select_pins != 2'h0 && $stable(range_select_pins) && $past(rst_b, 2)
            |=> conv_range_a == $past(range_select_pins);
    endproperty
    a_range: assert property (p_range) else $error("range pins not applied");
    property p_down;
        disable iff (1'b0) low_cnt >= 6'h20 |-> shutdown;
    endproperty
    a_down: assert property (p_down) else $error("no shutdown");
    property p_wake;
        $rose(rst_b) |-> ##2 !shutdown;
    endproperty
    a_wake: assert property (p_wake) else $error("shutdown kept");
    property p_ref;
        $rose(rst_b) |-> ##2 int_ref_enable == $past(reference_source_select, 2);
    endproperty
    a_ref: assert property (p_ref) else $error("reference mode wrong");
    property p_mode;
        $rose(rst_b) |-> ##2 software_mode == ($past(range_select_pins, 2) == 2'h0);
    endproperty
    a_mode: assert property (p_mode) else $error("mode wrong");
endmodule
bind dsoc_ctrl dsoc_checker i_checker (.sys_clk, .rst_b, .range_select_pins, .channel_pair_select_pins,
    .reference_source_select, .conversion_start, .busy, .conv_chan_a, .conv_chan_b, .conv_range_a,
    .sample_strobe, .int_ref_enable, .shutdown, .software_mode);
`default_nettype wire

// ### testbench/dsoc_host_model.sv
// Partner model: host that raises conversion start and watches busy
`timescale 1ns/1ps
`default_nettype none
module dsoc_host_model (
    input wire logic sys_clk,
    input wire logic go,
    input wire logic busy,
    output logic     conversion_start
);
    initial conversion_start = 1'b0;
    // Starts only while idle; held until busy answers so no edge is lost
    always @(posedge sys_clk) begin
        if (go && !busy) begin
            conversion_start <= 1'b1;
        end else if (busy) begin
            conversion_start <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### testbench/dsoc_ctrl_bench.sv
// Testbench: hardware and software mode runs of the converter control block
`timescale 1ns/1ps
`default_nettype none
module dsoc_ctrl_bench;
    import dsoc_pkg::*;
    logic        sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, go, diag;
    logic        reference_source_select, conversion_start, busy, sample_strobe, result_valid;
    logic        int_ref_enable, shutdown, software_mode, last_err;
    logic [1:0]  range_select_pins, conv_range_a, conv_range_b, last_ra, last_rb;
    logic [2:0]  channel_pair_select_pins;
    logic [3:0]  conv_chan_a, conv_chan_b, last_ca, last_cb;
    logic [7:0]  paddr;
    logic [15:0] sample_a, sample_b, result_a, result_b;
    logic [31:0] pwdata, prdata, rd, na, nb, smp;
    int          seed = 32'hfde8;
    int          fails = 0;
    int          comparisons = 0;
    int          qa[$];
    int          qb[$];
    int          ea, eb;
    dsoc_ctrl i_dut (.sys_clk, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .range_select_pins, .channel_pair_select_pins, .reference_source_select,
        .conversion_start, .sample_a, .sample_b, .busy, .conv_chan_a, .conv_chan_b, .conv_range_a,
        .conv_range_b, .sample_strobe, .result_a, .result_b, .result_valid, .int_ref_enable,
        .shutdown, .software_mode);
    dsoc_host_model i_host (.sys_clk, .go, .busy, .conversion_start);
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // Fresh data per slot, so a lost or repeated sample changes the average
    always @(posedge sys_clk) begin
        if (sample_strobe === 1'b1) begin
            smp = $random(seed);
            sample_a <= smp[15:0];
            sample_b <= smp[31:16];
            qa.push_back(int'($signed(smp[15:0])));
            qb.push_back(int'($signed(smp[31:16])));
            last_ca = conv_chan_a;
            last_cb = conv_chan_b;
            last_ra = conv_range_a;
            last_rb = conv_range_b;
        end
    end
    task automatic final_report();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            fails++;
            final_report();
        end
        @(posedge sys_clk);
    endtask
    task automatic convert(input int os);
        int n, bl, sa, sb;
        qa.delete();
        qb.delete();
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        n = 0;
        bl = 0;
        while (result_valid !== 1'b1 && n < 4000) begin
            @(posedge sys_clk);
            n++;
            if (busy === 1'b1) bl++;
        end
        if (n >= 4000) begin
            fails++;
            final_report();
        end
        sa = 0;
        sb = 0;
        foreach (qa[i]) sa += qa[i];
        foreach (qb[i]) sb += qb[i];
        ea = sa >>> os;
        eb = sb >>> os;
        check(qa.size(), 1 << os);
        check(result_a, ea[15:0]);
        check(result_b, eb[15:0]);
        check(bl >= (SAMPLE_CYC << os) && bl <= (SAMPLE_CYC << os) + 3, 1'b1);
    endtask
    task automatic sw_reset();
        rst_b <= 1'b0;
        range_select_pins <= 2'h0;
        reference_source_select <= 1'b0;
        repeat (40) @(posedge sys_clk);
        check(shutdown, 1'b1);
        rst_b <= 1'b1;
        repeat (3) @(posedge sys_clk);
        check({shutdown, int_ref_enable, software_mode}, 3'h1);
        // Settle wait kept at twice the 3000-cycle wait after a range pin change
        repeat (6000) @(posedge sys_clk);
    endtask
    initial begin
        {rst_b, psel, penable, pwrite, go} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        {sample_a, sample_b} = 32'h0;
        range_select_pins = 2'h3;
        channel_pair_select_pins = 3'h5;
        reference_source_select = 1'b1;
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge sys_clk);
        check({int_ref_enable, software_mode}, 2'h2);
        apb(1'b1, CFG_OFFSET, 32'h3);
        apb(1'b0, CFG_OFFSET, 32'h0);
        check(rd, 32'h0);
        for (int k = 1; k < 4; k++) begin
            range_select_pins <= 2'(k);
            repeat (3000) @(posedge sys_clk);
            convert(0);
            check({last_ca, last_cb}, 8'h5d);
            check({last_ra, last_rb}, {2'(k), 2'(k)});
        end
        sw_reset();
        apb(1'b0, 8'h20, 32'h0);
        check(last_err, 1'b1);
        for (int os = 0; os < 8; os++) begin
            na = $random(seed);
            nb = na | 32'h5555_5555;
            diag = (os == 7);
            apb(1'b1, CFG_OFFSET, 32'(os));
            apb(1'b1, CHAN_OFFSET, {23'h0, diag, 1'b0, na[6:4], 1'b0, na[2:0]});
            apb(1'b1, RANGE_A_OFFSET, {16'h0, nb[15:0]});
            apb(1'b1, RANGE_B_OFFSET, {16'h0, nb[31:16]});
            apb(1'b0, CFG_OFFSET, 32'h0);
            check(rd[2:0], os[2:0]);
            convert(os);
            check({last_ca, last_cb}, {diag, na[2:0], 1'b1, na[6:4]});
            if (!diag) check(last_ra, 2'(nb >> (2 * na[2:0])));
            check(last_rb, 2'(nb >> (16 + 2 * na[6:4])));
            apb(1'b0, RESULT_OFFSET, 32'h0);
            check(rd, {eb[15:0], ea[15:0]});
        end
        sw_reset();
        apb(1'b0, CFG_OFFSET, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, RANGE_B_OFFSET, 32'h0);
        check(rd, 32'(RANGE_RESET));
        final_report();
    end
endmodule
`default_nettype wire
